// file: hdl/bpsc_defs.svh
/*
 constants for the buck pair set-point block: register fields, reset values,
 arrangement codes. assumes inclusion by bare name from design files.
*/
`ifndef BPSC_DEFS_SVH
`define BPSC_DEFS_SVH
`define BPSC_RANGE_BIT        6
`define BPSC_CODE_W           6
`define BPSC_ARR_SINGLE0      2'h0
`define BPSC_ARR_SINGLE1      2'h1
`define BPSC_ARR_RESERVED     2'h2
`define BPSC_ARR_INDEP        2'h3
`define BPSC_LOW_BASE_MV      14'h0190
`define BPSC_LOW_STEP_MV      14'h0019
`define BPSC_HIGH_BASE_MV     14'h0320
`define BPSC_HIGH_STEP_MV     14'h0032
`define BPSC_SETPOINT_RST     6'h00
`endif

// file: hdl/bpsc_pkg.sv
/*
 types for the buck pair set-point block. assumes nothing of its surroundings.
*/
package bpsc_pkg;
    typedef enum logic [2:0] {
        BPSC_MODE_NORMAL  = 3'h1,
        BPSC_MODE_STANDBY = 3'h2,
        BPSC_MODE_SLEEP   = 3'h4
    } bpsc_mode_e;
    typedef logic [13:0] bpsc_mv_t;
endpackage

// file: hdl/bpsc_top.sv
/*
 set-point and arrangement logic for a pair of buck channels.
 assumes an i2c register front end on clk_sys giving per-channel write strobes,
 and otp straps (arrangement, range bits) stable from before reset release.
*/
// Notes on behaviour
// - read two-bit arrangement: 00/01 single, 11 independent
// - independent: each channel uses only its registers
// - range bit read-only, taken from otp
// - range 0: 0.40 to 1.975 V, 25 mV
// - range 1: 0.800 to 3.950 V, 50 mV
// - separate normal, standby, sleep fields; apply current
// - copy initial range bit to standby, sleep
// - code 0000000 is 0.4 V, 1000000 0.8 V
`timescale 1ns/1ps
`include "bpsc_defs.svh"
module bpsc_top
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // otp straps
    input  wire logic [1:0]            phase_arrangement_field,
    input  wire logic [1:0]            otp_range,
    // register writes, index 0 first channel, 1 second channel
    input  wire logic [1:0]            wr_normal,
    input  wire logic [1:0]            wr_standby,
    input  wire logic [1:0]            wr_sleep,
    input  wire logic [6:0]            wr_data,
    // operating mode, one-hot normal/standby/sleep
    input  wire logic [2:0]            op_mode,
    // register read-back
    output logic [6:0]                 buck_normal_voltage_a,
    output logic [6:0]                 buck_normal_voltage_b,
    // status and targets
    output logic                       phase_arrangement_select,
    output logic [13:0]                target_mv_a,
    output logic [13:0]                target_mv_b
);
    logic [1:0]  arr_s1, arr_s2;
    logic [1:0]  rng_s1, rng_s2;
    logic        loaded;
    logic [1:0]  rng;
    logic [5:0]  nrm [2];
    logic [5:0]  stb [2];
    logic [5:0]  slp [2];
    logic        next_loaded;
    logic [1:0]  next_rng;
    logic        next_sel;
    logic [5:0]  next_nrm [2];
    logic [5:0]  next_stb [2];
    logic [5:0]  next_slp [2];
    logic [13:0] next_mv [2];
    logic [13:0] mv [2];
    logic [5:0]  code [2];
    logic [1:0]  warm;
    logic [1:0]  next_warm;
    logic [1:0]  rsel;

    // straps come from otp outside this clock, so synchronise first
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            arr_s1 <= 2'h0;
            arr_s2 <= 2'h0;
            rng_s1 <= 2'h0;
            rng_s2 <= 2'h0;
        end
        else
        begin
            arr_s1 <= phase_arrangement_field;
            arr_s2 <= arr_s1;
            rng_s1 <= otp_range;
            rng_s2 <= rng_s1;
        end
    end

    // range captured once after sync settles; software can never write it
    always_comb
    begin
        next_loaded = loaded;
        next_rng    = rng;
        next_sel    = phase_arrangement_select;
        // two edges of warm-up so the otp range has crossed the synchroniser
        next_warm   = {warm[0], 1'b1};
        if (!loaded && warm == 2'h3)
        begin
            next_loaded = 1'b1;
            next_rng    = rng_s2;
        end
        unique case (arr_s2)
            `BPSC_ARR_SINGLE0, `BPSC_ARR_SINGLE1: next_sel = 1'b0;
            `BPSC_ARR_INDEP:                      next_sel = 1'b1;
            `BPSC_ARR_RESERVED:                   next_sel = 1'b1;
        endcase
        for (int c = 0; c < 2; c++)
        begin
            next_nrm[c] = nrm[c];
            next_stb[c] = stb[c];
            next_slp[c] = slp[c];
            // each channel takes only its own strobes
            if (wr_normal[c])
                next_nrm[c] = wr_data[5:0];
            if (wr_standby[c])
                next_stb[c] = wr_data[5:0];
            if (wr_sleep[c])
                next_slp[c] = wr_data[5:0];
            if (op_mode == bpsc_pkg::BPSC_MODE_SLEEP)
                code[c] = next_slp[c];
            else if (op_mode == bpsc_pkg::BPSC_MODE_STANDBY)
                code[c] = next_stb[c];
            else
                code[c] = next_nrm[c];
            rsel[c] = next_rng[c];
            // in single arrangement the pair follows the first channel, range too
            if (c == 1 && !next_sel)
            begin
                code[c] = code[0];
                rsel[c] = next_rng[0];
            end
            if (rsel[c])
                next_mv[c] = `BPSC_HIGH_BASE_MV
                           + 14'(`BPSC_HIGH_STEP_MV * 14'(code[c]));
            else
                next_mv[c] = `BPSC_LOW_BASE_MV
                           + 14'(`BPSC_LOW_STEP_MV * 14'(code[c]));
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            loaded                   <= 1'b0;
            warm                     <= 2'h0;
            rng                      <= 2'h0;
            phase_arrangement_select <= 1'b0;
            for (int c = 0; c < 2; c++)
            begin
                nrm[c] <= `BPSC_SETPOINT_RST;
                stb[c] <= `BPSC_SETPOINT_RST;
                slp[c] <= `BPSC_SETPOINT_RST;
                mv[c]  <= `BPSC_LOW_BASE_MV;
            end
            buck_normal_voltage_a <= 7'h00;
            buck_normal_voltage_b <= 7'h00;
        end
        else
        begin
            loaded                   <= next_loaded;
            warm                     <= next_warm;
            rng                      <= next_rng;
            phase_arrangement_select <= next_sel;
            for (int c = 0; c < 2; c++)
            begin
                nrm[c] <= next_nrm[c];
                stb[c] <= next_stb[c];
                slp[c] <= next_slp[c];
                mv[c]  <= next_mv[c];
            end
            buck_normal_voltage_a <= {next_rng[0], next_nrm[0]};
            buck_normal_voltage_b <= {next_rng[1], next_nrm[1]};
        end
    end

    assign target_mv_a = mv[0];
    assign target_mv_b = mv[1];

    a_range_fixed: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(loaded) |-> $stable(rng))
        else $error("range bit changed after capture");
    a_low_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        (loaded && !rng[0] && op_mode == bpsc_pkg::BPSC_MODE_NORMAL && $stable(nrm[0]))
        |=> (mv[0] == 14'(14'd400 + 14'd25 * 14'(nrm[0]))))
        else $error("low range mapping wrong");
    a_high_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        (loaded && rng[0] && op_mode == bpsc_pkg::BPSC_MODE_NORMAL && $stable(nrm[0]))
        |=> (mv[0] == 14'(14'd800 + 14'd50 * 14'(nrm[0]))))
        else $error("high range mapping wrong");
    a_sel_decode: assert property (@(posedge clk_sys) disable iff (!rstn)
        1'b1 |=> (phase_arrangement_select == ($past(arr_s2) != 2'h0 && $past(arr_s2) != 2'h1)))
        else $error("arrangement decode wrong");
    a_reserved_indep: assert property (@(posedge clk_sys) disable iff (!rstn)
        (arr_s2 == 2'h2) |=> phase_arrangement_select)
        else $error("reserved code not independent");
    a_chan_isolate: assert property (@(posedge clk_sys) disable iff (!rstn)
        (wr_normal == 2'h1) |=> $stable(nrm[1]))
        else $error("second channel disturbed by first");
    a_sleep_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
        (loaded && op_mode == bpsc_pkg::BPSC_MODE_SLEEP && !rng[0] && !wr_sleep[0])
        |=> (mv[0] == 14'(14'd400 + 14'd25 * 14'($past(slp[0])))))
        else $error("sleep field not applied");
    a_zero_code: assert property (@(posedge clk_sys) disable iff (!rstn)
        (loaded && op_mode == bpsc_pkg::BPSC_MODE_NORMAL && nrm[0] == 6'h00 && !wr_normal[0])
        |=> (mv[0] == (rng[0] ? 14'd800 : 14'd400)))
        else $error("bottom code decode wrong");
    a_range_shared: assert property (@(posedge clk_sys) disable iff (!rstn)
        loaded |-> (buck_normal_voltage_a[6] == rng[0]) || !$past(loaded))
        else $error("range not shared");
    a_load_otp: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(loaded) |-> (rng == $past(rng_s2)))
        else $error("captured range differs from strap");
    a_standby_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        (loaded && op_mode == bpsc_pkg::BPSC_MODE_STANDBY && !wr_standby[0])
        |=> (mv[0] == (rng[0] ? 14'(14'd800 + 14'd50 * 14'($past(stb[0])))
                              : 14'(14'd400 + 14'd25 * 14'($past(stb[0]))))))
        else $error("standby range not shared");
    a_single_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
        !phase_arrangement_select |-> (mv[1] == mv[0]))
        else $error("second target not following first");
    c_single: cover property (@(posedge clk_sys) disable iff (!rstn)
        loaded && !phase_arrangement_select);
    c_indep: cover property (@(posedge clk_sys) disable iff (!rstn) phase_arrangement_select);
    c_sleep: cover property (@(posedge clk_sys) disable iff (!rstn)
        op_mode == bpsc_pkg::BPSC_MODE_SLEEP ##1 op_mode == bpsc_pkg::BPSC_MODE_NORMAL);
    c_high: cover property (@(posedge clk_sys) disable iff (!rstn) loaded && rng[0]);
endmodule // bpsc_top

// file: test/bpsc_top_bench.sv
/*
 self-checking bench for bpsc_top: drives straps, write strobes and mode.
 assumes the design files are compiled first.
*/
`timescale 1ns/1ps
module bpsc_top_bench;
    logic        clk_sys    = 1'b0;
    logic        rstn       = 1'b0;
    logic [1:0]  arr        = 2'h3;
    logic [1:0]  otp_range  = 2'h2;
    logic [1:0]  wr_normal  = 2'h0;
    logic [1:0]  wr_standby = 2'h0;
    logic [1:0]  wr_sleep   = 2'h0;
    logic [6:0]  wr_data    = 7'h00;
    logic [2:0]  op_mode    = bpsc_pkg::BPSC_MODE_NORMAL;
    logic [6:0]  rb_a;
    logic [6:0]  rb_b;
    logic        sel;
    logic [13:0] mv_a;
    logic [13:0] mv_b;
    int          failures   = 0;
    int          num_checks = 0;

    bpsc_top dut
    (
        .clk_sys                  (clk_sys),
        .rstn                     (rstn),
        .phase_arrangement_field  (arr),
        .otp_range                (otp_range),
        .wr_normal                (wr_normal),
        .wr_standby               (wr_standby),
        .wr_sleep                 (wr_sleep),
        .wr_data                  (wr_data),
        .op_mode                  (op_mode),
        .buck_normal_voltage_a    (rb_a),
        .buck_normal_voltage_b    (rb_b),
        .phase_arrangement_select (sel),
        .target_mv_a              (mv_a),
        .target_mv_b              (mv_b)
    );

    always #50 clk_sys = ~clk_sys;

    task chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task results;
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // settle on the falling edge so registered outputs have landed
    task wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task wr(input logic [1:0] n, input logic [1:0] s, input logic [1:0] o, input logic [6:0] d);
        @(posedge clk_sys);
        wr_normal  <= n;
        wr_standby <= s;
        wr_sleep   <= o;
        wr_data    <= d;
        @(posedge clk_sys);
        wr_normal  <= 2'h0;
        wr_standby <= 2'h0;
        wr_sleep   <= 2'h0;
        @(negedge clk_sys);
    endtask

    task mode(input logic [2:0] m);
        @(posedge clk_sys);
        op_mode <= m;
        wait_n(2);
    endtask

    task t_range_lock;
        chk("range a", 14'h0000, {13'h0000, rb_a[6]});
        chk("range b", 14'h0001, {13'h0000, rb_b[6]});
        // bit 6 of the write data must not reach either readback
        wr(2'h3, 2'h0, 2'h0, 7'h45);
        chk("readback a", 14'h0005, {7'h00, rb_a});
        chk("readback b", 14'h0045, {7'h00, rb_b});
        @(posedge clk_sys);
        otp_range <= 2'h1;
        wait_n(4);
        chk("late otp a", 14'h0005, {7'h00, rb_a});
    endtask

    task t_low;
        wr(2'h1, 2'h0, 2'h0, 7'h00);
        chk("low bottom", 14'h0190, mv_a);
        chk("b untouched", 14'h041A, mv_b);
        wr(2'h1, 2'h0, 2'h0, 7'h3F);
        chk("low top", 14'h07B7, mv_a);
        wr(2'h1, 2'h0, 2'h0, 7'h05);
        chk("low 5", 14'h020D, mv_a);
    endtask

    task t_high;
        wr(2'h2, 2'h0, 2'h0, 7'h00);
        chk("high bottom", 14'h0320, mv_b);
        wr(2'h2, 2'h0, 2'h0, 7'h18);
        chk("high 24", 14'h07D0, mv_b);
        chk("a untouched", 14'h020D, mv_a);
    endtask

    task t_modes;
        wr(2'h0, 2'h3, 2'h0, 7'h09);
        wr(2'h0, 2'h0, 2'h3, 7'h14);
        chk("normal kept", 14'h020D, mv_a);
        mode(bpsc_pkg::BPSC_MODE_STANDBY);
        chk("standby a", 14'h0271, mv_a);
        chk("standby b", 14'h04E2, mv_b);
        mode(bpsc_pkg::BPSC_MODE_SLEEP);
        chk("sleep a", 14'h0384, mv_a);
        chk("sleep b", 14'h0708, mv_b);
        mode(bpsc_pkg::BPSC_MODE_NORMAL);
        chk("normal b", 14'h07D0, mv_b);
        // undefined mode codes fall back to normal set-points
        mode(3'h0);
        chk("mode 000 b", 14'h07D0, mv_b);
        mode(bpsc_pkg::BPSC_MODE_NORMAL);
    endtask

    // reserved code is expected to behave as independent
    task t_arrangement;
        wr(2'h3, 2'h0, 2'h0, 7'h0A);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            arr <= i[1:0];
            wait_n(4);
            chk("select", (i >= 2) ? 14'h0001 : 14'h0000, {13'h0000, sel});
            chk("second target", (i >= 2) ? 14'h0514 : 14'h028A, mv_b);
        end
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        wait_n(4);
        t_range_lock;
        t_low;
        t_high;
        t_modes;
        t_arrangement;
        results;
    end
endmodule // bpsc_top_bench
